// file: verif/tci_timer_regs_props.sv
// concurrent checks on the timer capture and interrupt register slice
// assumes one clock domain and sees only the top module's ports
module tci_timer_regs_chk
    import tci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched inputs
    input wire tci_bus_t bus,
    input wire logic compat_mode,
    input wire logic global_irq_en,
    input wire logic acomp_select,
    input wire logic top_is_cap1,
    input wire logic [15:0] counter1_value,
    input wire logic capture1_pin_event,
    input wire logic acomp_event,
    input wire logic top1_reached,
    input wire logic cmp1a_match,
    input wire tci_t1_ev_t vector_ack,
    // watched outputs
    input wire tci_t1_ev_t irq_req_reg,
    input wire logic [7:0] flags_reg,
    input wire logic [7:0] mask_reg,
    input wire logic [7:0] xmask_reg,
    input wire logic [15:0] capture1_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic cap_set;
    assign cap_set = capture1_pin_event | acomp_event | top1_reached;
    a_reserved_zero: assert property (
        {flags_reg[7:6], mask_reg[7:6], xmask_reg[7:6]} == 6'h00)
        else $error("reserved bits set");
    a_cap_latch: assert property (
        capture1_pin_event && !acomp_select && !top_is_cap1 |=>
        capture1_value == $past(counter1_value) && flags_reg[5])
        else $error("capture not latched");
    a_cmpa_delay: assert property (cmp1a_match |-> ##2 flags_reg[4])
        else $error("compare flag late");
    a_cmpa_cause: assert property (
        $rose(flags_reg[4]) |-> $past(cmp1a_match, 2))
        else $error("compare flag without match");
    a_vector_clear: assert property (
        vector_ack.cap && !cap_set |=> !flags_reg[5])
        else $error("flag kept after vector");
    a_irq_cap: assert property (1'b1 |=> irq_req_reg.cap ==
        $past(flags_reg[5] && mask_reg[5] && global_irq_en))
        else $error("capture request wrong");
    a_irq_compare: assert property (1'b1 |=>
        irq_req_reg.cmp_a == $past(flags_reg[4] && mask_reg[4]
        && global_irq_en) && irq_req_reg.cmp_b == $past(flags_reg[3]
        && mask_reg[3] && global_irq_en) && irq_req_reg.ovf ==
        $past(flags_reg[2] && mask_reg[2] && global_irq_en))
        else $error("compare or overflow request wrong");
    a_mask_write: assert property (
        (bus.io_wr && bus.addr == OFS_MASK) ||
        (bus.ds_wr && bus.addr == OFS_MASK + IO_DATA_OFS) |=>
        mask_reg == ($past(bus.wdata) & 8'h3F))
        else $error("mask write wrong");
    a_xmask_guard: assert property (
        !(bus.ds_wr && bus.addr == OFS_XMASK && !compat_mode) |=>
        $stable(xmask_reg))
        else $error("extended mask changed");
endmodule // tci_timer_regs_chk

bind tci_timer_regs tci_timer_regs_chk chk (.clk, .nrst, .bus,
    .compat_mode, .global_irq_en, .acomp_select, .top_is_cap1,
    .counter1_value, .capture1_pin_event, .acomp_event, .top1_reached,
    .cmp1a_match, .vector_ack, .irq_req_reg, .flags_reg, .mask_reg,
    .xmask_reg, .capture1_value);

// file: verif/tci_timer_regs_tb_top.sv
// self-checking bench for the timer capture and interrupt registers
// drives all ports at the falling edge; reads are checked from a queue
module tci_timer_regs_tb_top import tci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, compat_mode = 1'b0, top_is_cap1 = 1'b0;
    logic global_irq_en = 1'b0, acomp_select = 1'b0, top_is_cap3 = 1'b0;
    tci_bus_t bus = '0;
    tci_t1_ev_t vack = '0, irq_req_reg;
    logic [8:0] ev = '0;
    logic [15:0] cnt1 = '0, cnt3 = '0, v;
    logic [15:0] capture1_value, capture3_value, compare3c_value;
    logic [7:0] oth = '0, rdata_reg, flags_reg, mask_reg, xmask_reg, e;
    logic [7:0] expq[$];
    logic [7:0] ra[10] = '{8'h46, 8'h47, 8'h56, 8'h57, 8'h7D, 8'h80,
        8'h81, 8'h82, 8'h83, 8'h60};
    int n_errors = 0, checks = 0, seed = 29;
    always #4 clk = ~clk;
    tci_timer_regs uut (.clk, .nrst, .bus, .rdata_reg, .compat_mode,
        .global_irq_en, .acomp_select, .top_is_cap1, .top_is_cap3,
        .counter1_value(cnt1), .capture1_pin_event(ev[0]),
        .acomp_event(ev[1]), .top1_reached(ev[2]), .cmp1a_match(ev[3]),
        .cmp1b_match(ev[4]), .ovf1_event(ev[5]),
        .forced_compare_strobe(ev[6]), .vector_ack(vack),
        .counter3_value(cnt3), .capture3_pin_event(ev[7]),
        .top3_reached(ev[8]), .other_flags_set(oth), .irq_req_reg,
        .flags_reg, .mask_reg, .xmask_reg, .capture1_value,
        .capture3_value, .compare3c_value);
    // k: 0 io read, 1 io write, 2 data read, 3 data write
    task automatic acc(input int k, input logic [7:0] a, d, x);
        if (k == 0 || k == 2) expq.push_back(x);
        bus = '{k == 0, k == 1, k == 2, k == 3, a, d};
        @(negedge clk);
        bus = '0;
        @(negedge clk);
    endtask
    task automatic pulse(input logic [8:0] b, input logic [3:0] a = 4'h0,
        input logic [7:0] o = 8'h00);
        ev = b;
        vack = a;
        oth = o;
        @(negedge clk);
        ev = '0;
        vack = '0;
        oth = '0;
        repeat (2) @(negedge clk);
    endtask
    // direct look at a settled status output
    task automatic look(input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        if (bus.io_rd || bus.ds_rd) begin
            @(negedge clk);
            e = expq.pop_front();
            checks++;
            if (rdata_reg !== e) begin
                n_errors++;
                $display("CHECK FAILED %0t got %h exp %h", $time,
                    rdata_reg, e);
            end
        end
    end
    // the sequence needs well under 1000 cycles
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        foreach (ra[i]) acc(2, ra[i], 8'h00, 8'h00);
        acc(1, OFS_MASK, 8'hFF, 8'h00);
        acc(2, 8'h57, 8'h00, 8'h3F);
        acc(0, OFS_MASK, 8'h00, 8'h3F);
        v = 16'($random(seed));
        acc(3, OFS_CMP3C_HI, v[15:8], 8'h00);
        acc(3, OFS_CMP3C_LO, v[7:0], 8'h00);
        look(compare3c_value, v);
        acc(2, OFS_CMP3C_LO, 8'h00, v[7:0]);
        acc(2, OFS_CMP3C_HI, 8'h00, v[15:8]);
        global_irq_en = 1'b1;
        cnt1 = 16'($random(seed));
        v = cnt1;
        pulse(9'h001);
        cnt1 = ~cnt1;
        look(capture1_value, v);
        look({12'h000, irq_req_reg}, 16'h0008);
        acc(2, 8'h46, 8'h00, v[7:0]);
        acc(0, OFS_CAP1_HI, 8'h00, v[15:8]);
        acc(1, OFS_FLAGS, 8'h00, 8'h00);
        acc(2, 8'h56, 8'h00, 8'h20);
        acc(1, OFS_FLAGS, 8'h20, 8'h00);
        acc(0, OFS_FLAGS, 8'h00, 8'h00);
        acomp_select = 1'b1;
        pulse(9'h001);
        acc(0, OFS_CAP1_LO, 8'h00, v[7:0]);
        v = cnt1;
        pulse(9'h002);
        acc(0, OFS_CAP1_LO, 8'h00, v[7:0]);
        acc(0, OFS_CAP1_HI, 8'h00, v[15:8]);
        pulse(9'h000, 4'h8);
        acomp_select = 1'b0;
        top_is_cap1 = 1'b1;
        pulse(9'h001);
        acc(0, OFS_FLAGS, 8'h00, 8'h00);
        pulse(9'h004);
        acc(0, OFS_FLAGS, 8'h00, 8'h20);
        top_is_cap1 = 1'b0;
        pulse(9'h040);
        acc(0, OFS_FLAGS, 8'h00, 8'h20);
        pulse(9'h038, 4'h0, 8'hFF);
        look({12'h000, irq_req_reg}, 16'h000F);
        acc(0, OFS_FLAGS, 8'h00, 8'h3F);
        acc(1, OFS_FLAGS, 8'h3C, 8'h00);
        acc(0, OFS_FLAGS, 8'h00, 8'h03);
        pulse(9'h038);
        pulse(9'h000, 4'hF);
        look({12'h000, irq_req_reg}, 16'h0000);
        acc(0, OFS_FLAGS, 8'h00, 8'h03);
        compat_mode = 1'b1;
        acc(3, OFS_XMASK, 8'hFF, 8'h00);
        acc(2, OFS_XMASK, 8'h00, 8'h00);
        compat_mode = 1'b0;
        acc(1, OFS_XMASK, 8'hFF, 8'h00);
        acc(2, OFS_XMASK, 8'h00, 8'h00);
        acc(3, OFS_XMASK, 8'hFF, 8'h00);
        acc(2, OFS_XMASK, 8'h00, 8'h3F);
        cnt3 = 16'($random(seed));
        v = cnt3;
        pulse(9'h080);
        acc(2, OFS_CAP3_LO, 8'h00, v[7:0]);
        acc(2, OFS_CAP3_HI, 8'h00, v[15:8]);
        look(capture3_value, v);
        top_is_cap3 = 1'b1;
        cnt3 = ~cnt3;
        pulse(9'h080);
        look(capture3_value, v);
        complete_run();
    end
endmodule // tci_timer_regs_tb_top

// file: verilog/tci_capture.sv
// one 16-bit capture unit: latches the counter on an event
// assumes event strobes are one-cycle pulses synchronous to clk
module tci_capture
    import tci_pkg::*;
#(
    parameter int unsigned WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // events
    input wire logic pin_event,
    input wire logic top_event,
    input wire logic top_is_capture,
    input wire logic [WIDTH-1:0] counter_value,
    // software write of the full word
    input wire logic sw_write,
    input wire logic [WIDTH-1:0] sw_value,
    // results
    output logic [WIDTH-1:0] value_reg,
    output logic event_pulse
);
    logic take;

    // as top value, pin events no longer capture; flag follows top
    assign take = pin_event & ~top_is_capture;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            value_reg <= '0;
        end else if (sw_write) begin
            value_reg <= sw_value;
        end else if (take) begin
            value_reg <= counter_value; // RL1
        end
    end

    assign event_pulse = top_is_capture ? top_event : pin_event; // RL15
endmodule // tci_capture

// file: verilog/tci_pkg.sv
// constants and carrier types for the timer capture and interrupt registers
// assumes one clock domain; short offsets are i/o addresses, extended offsets are data-space byte addresses
package tci_pkg;
    localparam int unsigned DW = 8;
    localparam int unsigned AW = 8;
    localparam int unsigned CW = 16;
    // short i/o range and its data-space displacement
    localparam logic [7:0] IO_SHORT_LAST = 8'h3F;
    localparam logic [7:0] IO_DATA_OFS = 8'h20;
    localparam logic [7:0] EXT_IO_BASE = 8'h60;
    // i/o offsets
    localparam logic [7:0] OFS_CAP1_LO = 8'h26;
    localparam logic [7:0] OFS_CAP1_HI = 8'h27;
    localparam logic [7:0] OFS_FLAGS = 8'h36;
    localparam logic [7:0] OFS_MASK = 8'h37;
    // extended offsets, data space only
    localparam logic [7:0] OFS_XMASK = 8'h7D;
    localparam logic [7:0] OFS_CAP3_LO = 8'h80;
    localparam logic [7:0] OFS_CAP3_HI = 8'h81;
    localparam logic [7:0] OFS_CMP3C_LO = 8'h82;
    localparam logic [7:0] OFS_CMP3C_HI = 8'h83;
    // timer-1 bit positions in mask and flag registers
    localparam int unsigned BIT_CAP1 = 5;
    localparam int unsigned BIT_CMP1A = 4;
    localparam int unsigned BIT_CMP1B = 3;
    localparam int unsigned BIT_OVF1 = 2;
    localparam logic [7:0] T1_BITS = 8'h3C;
    localparam logic [7:0] XMASK_BITS = 8'h3F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef struct packed {
        logic cap;
        logic cmp_a;
        logic cmp_b;
        logic ovf;
    } tci_t1_ev_t;

    typedef struct packed {
        logic io_rd;
        logic io_wr;
        logic ds_rd;
        logic ds_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tci_bus_t;
endpackage

// file: verilog/tci_timer_regs.sv
// register slice of timers 1 and 3: captures, compare 3c, shared latch,
// mask and flag registers
// assumes a one-cycle cpu access strobe and event pulses on clk
//
// Behaviour
// RL1 - counter copied into capture on pin event
// RL2 - capture register may act as top
// RL3 - 16-bit capture read through high latch
// RL4 - one shared latch for all words
// RL5 - short i/o also at data address plus 0x20
// RL6 - extended registers only by data space
// RL7 - capture irq needs mask5, global, flag
// RL8 - mask bits 4,3,2 gate compare/overflow irqs
// RL9 - flag bits 5..2 for timer 1
// RL10 - extended mask bits for timer 3, 1c
// RL11 - extended mask hidden in compatibility mode
// RL12 - only timer-1 bits of shared registers touched
// RL13 - flags cleared by vector or written one
// RL14 - compare flag set cycle after match
// RL15 - capture-as-top flags at top reached
// RL16 - forced compare strobe sets no flag
// RL17 - write zero keeps flag; bits 7,6 zero
// RL18 - low read loads high byte into latch
module tci_timer_regs
    import tci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // cpu register access
    input wire tci_bus_t bus,
    output logic [7:0] rdata_reg,
    // configuration
    input wire logic compat_mode,
    input wire logic global_irq_en,
    input wire logic acomp_select,
    input wire logic top_is_cap1,
    input wire logic top_is_cap3,
    // timer 1 side
    input wire logic [15:0] counter1_value,
    input wire logic capture1_pin_event,
    input wire logic acomp_event,
    input wire logic top1_reached,
    input wire logic cmp1a_match,
    input wire logic cmp1b_match,
    input wire logic ovf1_event,
    input wire logic forced_compare_strobe,
    input wire tci_t1_ev_t vector_ack,
    // timer 3 side
    input wire logic [15:0] counter3_value,
    input wire logic capture3_pin_event,
    input wire logic top3_reached,
    // other timers' bits of the shared registers
    input wire logic [7:0] other_flags_set,
    // outputs
    output tci_t1_ev_t irq_req_reg,
    output logic [7:0] flags_reg,
    output logic [7:0] mask_reg,
    output logic [7:0] xmask_reg,
    output logic [15:0] capture1_value,
    output logic [15:0] capture3_value,
    output logic [15:0] compare3c_value
);
    logic [7:0] temp_reg;
    logic [7:0] ioa;
    logic hit_io, rd, wr;
    logic cap1_ev, cap1_pin;
    logic [15:0] cap1_q, cap3_q;
    logic [7:0] set_bits, clr_bits;
    logic cmp1a_d_reg, cmp1b_d_reg;

    // short-range access maps both routes to one i/o offset
    always_comb begin
        ioa = bus.addr;
        hit_io = 1'b0;
        if ((bus.io_rd | bus.io_wr) && bus.addr <= IO_SHORT_LAST) begin
            hit_io = 1'b1; // RL5
        end else if ((bus.ds_rd | bus.ds_wr)
                     && bus.addr >= IO_DATA_OFS
                     && bus.addr < EXT_IO_BASE) begin
            ioa = bus.addr - IO_DATA_OFS; // RL5
            hit_io = 1'b1;
        end
    end
    // extended space answers data-space access only
    assign rd = hit_io ? (bus.io_rd | bus.ds_rd) : bus.ds_rd; // RL6
    assign wr = hit_io ? (bus.io_wr | bus.ds_wr) : bus.ds_wr; // RL6

    function automatic logic sel(input logic [7:0] ofs, input logic io);
        sel = io ? (hit_io && ioa == ofs) : (!hit_io && bus.addr == ofs);
    endfunction

    assign cap1_pin = acomp_select ? acomp_event : capture1_pin_event; // RL1

    tci_capture #(.WIDTH(16)) u_cap1 (
        .clk(clk),
        .nrst(nrst),
        .pin_event(cap1_pin),
        .top_event(top1_reached),
        .top_is_capture(top_is_cap1), // RL2
        .counter_value(counter1_value),
        .sw_write(wr && sel(OFS_CAP1_LO, 1'b1)),
        .sw_value({temp_reg, bus.wdata}),
        .value_reg(cap1_q),
        .event_pulse(cap1_ev)
    );
    tci_capture #(.WIDTH(16)) u_cap3 (
        .clk(clk),
        .nrst(nrst),
        .pin_event(capture3_pin_event),
        .top_event(top3_reached),
        .top_is_capture(top_is_cap3), // RL2
        .counter_value(counter3_value),
        .sw_write(wr && sel(OFS_CAP3_LO, 1'b0)),
        .sw_value({temp_reg, bus.wdata}),
        .value_reg(cap3_q),
        // timer-3 flag sits in the extended flag register, not here
        .event_pulse()
    );
    assign capture1_value = cap1_q;
    assign capture3_value = cap3_q;

    // single latch: high writes park here, low reads fill it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            temp_reg <= RESET_BYTE;
        end else if (wr && (sel(OFS_CAP1_HI, 1'b1) || sel(OFS_CAP3_HI, 1'b0)
                     || sel(OFS_CMP3C_HI, 1'b0))) begin
            temp_reg <= bus.wdata; // RL4
        end else if (rd && sel(OFS_CAP1_LO, 1'b1)) begin
            temp_reg <= cap1_q[15:8]; // RL18
        end else if (rd && sel(OFS_CAP3_LO, 1'b0)) begin
            temp_reg <= cap3_q[15:8]; // RL18
        end else if (rd && sel(OFS_CMP3C_LO, 1'b0)) begin
            temp_reg <= compare3c_value[15:8]; // RL18
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compare3c_value <= RESET_WORD;
        end else if (wr && sel(OFS_CMP3C_LO, 1'b0)) begin
            compare3c_value <= {temp_reg, bus.wdata}; // RL4
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= RESET_BYTE;
        end else if (wr && sel(OFS_MASK, 1'b1)) begin
            mask_reg <= bus.wdata & ~8'hC0; // RL17
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xmask_reg <= RESET_BYTE;
        end else if (wr && sel(OFS_XMASK, 1'b0) && !compat_mode) begin
            xmask_reg <= bus.wdata & XMASK_BITS; // RL10 RL11
        end
    end

    // compare flag lands two cycles after the match; forced strobes
    // never reach this path
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmp1a_d_reg <= 1'b0;
            cmp1b_d_reg <= 1'b0;
        end else begin
            cmp1a_d_reg <= cmp1a_match; // RL14 RL16
            cmp1b_d_reg <= cmp1b_match; // RL14 RL16
        end
    end

    always_comb begin
        set_bits = other_flags_set & ~T1_BITS; // RL12
        set_bits[BIT_CAP1] = cap1_ev; // RL9
        set_bits[BIT_CMP1A] = cmp1a_d_reg;
        set_bits[BIT_CMP1B] = cmp1b_d_reg;
        set_bits[BIT_OVF1] = ovf1_event;
        clr_bits = (wr && sel(OFS_FLAGS, 1'b1)) ? bus.wdata : RESET_BYTE;
        clr_bits[BIT_CAP1] = clr_bits[BIT_CAP1] | vector_ack.cap; // RL13
        clr_bits[BIT_CMP1A] = clr_bits[BIT_CMP1A] | vector_ack.cmp_a;
        clr_bits[BIT_CMP1B] = clr_bits[BIT_CMP1B] | vector_ack.cmp_b;
        clr_bits[BIT_OVF1] = clr_bits[BIT_OVF1] | vector_ack.ovf;
    end

    // set wins over clear; bits 7,6 stay zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= RESET_BYTE;
        end else begin
            flags_reg <= ((flags_reg & ~clr_bits) | set_bits)
                         & ~8'hC0; // RL13 RL17
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_req_reg <= '0;
        end else begin
            irq_req_reg.cap <= global_irq_en & mask_reg[BIT_CAP1]
                               & flags_reg[BIT_CAP1]; // RL7
            irq_req_reg.cmp_a <= global_irq_en & mask_reg[BIT_CMP1A]
                                 & flags_reg[BIT_CMP1A]; // RL8
            irq_req_reg.cmp_b <= global_irq_en & mask_reg[BIT_CMP1B]
                                 & flags_reg[BIT_CMP1B]; // RL8
            irq_req_reg.ovf <= global_irq_en & mask_reg[BIT_OVF1]
                               & flags_reg[BIT_OVF1]; // RL8
        end
    end

    // read data registered; high bytes come from the shared latch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= RESET_BYTE;
        end else if (rd) begin
            if (sel(OFS_CAP1_LO, 1'b1)) rdata_reg <= cap1_q[7:0];
            else if (sel(OFS_CAP3_LO, 1'b0)) rdata_reg <= cap3_q[7:0];
            else if (sel(OFS_CMP3C_LO, 1'b0))
                rdata_reg <= compare3c_value[7:0];
            else if (sel(OFS_CAP1_HI, 1'b1) || sel(OFS_CAP3_HI, 1'b0)
                     || sel(OFS_CMP3C_HI, 1'b0))
                rdata_reg <= temp_reg; // RL3
            else if (sel(OFS_FLAGS, 1'b1)) rdata_reg <= flags_reg;
            else if (sel(OFS_MASK, 1'b1)) rdata_reg <= mask_reg;
            else if (sel(OFS_XMASK, 1'b0) && !compat_mode)
                rdata_reg <= xmask_reg; // RL11
            else rdata_reg <= RESET_BYTE;
        end
    end
endmodule // tci_timer_regs
